// *** design/swcrt_top.sv ***
// Wait slot, slow clock gating and reset release timing of the power sequencer
`timescale 1ns/1ps
`include "swcrt_defines.svh"
module swcrt_top #(
	parameter int TICK_CYCLES = `SWCRT_TICK_CYCLES,
	parameter int TIMEOUT_TICKS = `SWCRT_TIMEOUT_TICKS
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Register port
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	// Sequencer slot engine
	input wire logic [3:0] seqSlotIndex,
	input wire logic seqSlotStart,
	input wire logic seqDirUp,
	output logic seqHold,
	output logic waitTimedOut,
	// External wait pin
	input wire logic external_hold_input,
	// Slow clock
	input wire logic slowClockIn,
	input wire logic oscillatorOn,
	input wire logic slow_clock_output_pause,
	input wire logic backupCrystalPresent,
	output logic counterClock,
	output logic slow_clock_output,
	output logic settleDone,
	// Reset release triggers and output
	input wire logic external_wake,
	input wire logic system_domain_up,
	input wire logic power_domain_up,
	input wire logic leaveResetMode,
	output logic system_reset_out_n
);
	import swcrt_pkg::*;

	// Register fields
	logic [7:0] stepIndex_r;
	logic [7:0] waitCtrl_r;
	logic [7:0] gateCtrl_r;
	logic [7:0] releaseCtrl_r;
	logic [7:0] regRdData_r;
	logic crystalLoaded_r;

	logic [1:0] waitDir;
	logic waitTimeoutEn;
	logic waitSrcTimer;
	logic [3:0] waitTime;
	logic [2:0] settleCode;
	swcrt_trigger_type trigSel;
	logic [5:0] releaseCode;

	assign waitDir = waitCtrl_r[`SWCRT_WAIT_DIR_MSB:`SWCRT_WAIT_DIR_LSB];
	assign waitTimeoutEn = waitCtrl_r[`SWCRT_WAIT_TIMEOUT_BIT];
	assign waitSrcTimer = waitCtrl_r[`SWCRT_WAIT_SRC_BIT];
	assign waitTime = waitCtrl_r[`SWCRT_WAIT_TIME_MSB:`SWCRT_WAIT_TIME_LSB];
	assign settleCode = gateCtrl_r[`SWCRT_GATE_SETTLE_MSB:`SWCRT_GATE_SETTLE_LSB];
	assign trigSel = swcrt_trigger_type'(releaseCtrl_r[`SWCRT_REL_EVENT_MSB:`SWCRT_REL_EVENT_LSB]);
	assign releaseCode = releaseCtrl_r[`SWCRT_REL_TIMER_MSB:`SWCRT_REL_TIMER_LSB];

	// Duration code to ticks of 512 us, doubling per step
	function automatic swcrt_ticks_type waitTicks(input logic [3:0] code);
		swcrt_ticks_type t;
		t = '0;
		if (code != 4'h0) begin
			t = swcrt_ticks_type'(16'h0001 << (code - 4'h1));
		end
		return t;
	endfunction : waitTicks

	// Settle code to ticks, steps of about 0.52 s
	function automatic swcrt_ticks_type settleTicks(input logic [2:0] code);
		return swcrt_ticks_type'(code * `SWCRT_SETTLE_STEP_TICKS);
	endfunction : settleTicks

	// Release code to ticks, linear then coarse
	function automatic swcrt_ticks_type releaseTicks(input logic [5:0] code);
		swcrt_ticks_type t;
		t = '0;
		if (code < 6'h20) begin
			t = swcrt_ticks_type'(code * `SWCRT_RELEASE_UNIT_TICKS);
		end else begin
			t = swcrt_ticks_type'((code - `SWCRT_RELEASE_LONG_BASE)
				* `SWCRT_RELEASE_LONG_MULT * `SWCRT_RELEASE_UNIT_TICKS);
		end
		return t;
	endfunction : releaseTicks

	// Register writes; crystal bit caught once after reset release
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			stepIndex_r <= `SWCRT_RST_STEP_INDEX;
			waitCtrl_r <= `SWCRT_RST_WAIT_CTRL;
			gateCtrl_r <= `SWCRT_RST_GATE_CTRL;
			releaseCtrl_r <= `SWCRT_RST_RELEASE_CTRL;
			crystalLoaded_r <= 1'b0;
		end else begin
			crystalLoaded_r <= 1'b1;
			if (!crystalLoaded_r) begin
				gateCtrl_r[`SWCRT_GATE_CRYSTAL_BIT] <= backupCrystalPresent;
			end else if (regWrEn && regAddr == `SWCRT_ADDR_GATE_CTRL) begin
				gateCtrl_r <= regWrData;
			end
			if (regWrEn && regAddr == `SWCRT_ADDR_STEP_INDEX) begin
				stepIndex_r <= regWrData;
			end
			if (regWrEn && regAddr == `SWCRT_ADDR_WAIT_CTRL) begin
				waitCtrl_r <= regWrData;
			end
			if (regWrEn && regAddr == `SWCRT_ADDR_RELEASE_CTRL) begin
				releaseCtrl_r <= regWrData;
			end
		end
	end

	// Read data; unmapped addresses read zero
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdData_r <= 8'h00;
		end else if (regRdEn) begin
			unique case (regAddr)
				`SWCRT_ADDR_STEP_INDEX: regRdData_r <= stepIndex_r;
				`SWCRT_ADDR_WAIT_CTRL: regRdData_r <= waitCtrl_r;
				`SWCRT_ADDR_GATE_CTRL: regRdData_r <= gateCtrl_r;
				`SWCRT_ADDR_RELEASE_CTRL: regRdData_r <= releaseCtrl_r;
				default: regRdData_r <= 8'h00;
			endcase
		end
	end

	// Pin synchronisers, three stages; a level counts once stages two and three agree
	logic [2:0] holdSync_r;
	logic [2:0] slowSync_r;
	logic [2:0] oscSync_r;
	logic holdLevel_r;
	logic slowLevel_r;
	logic oscLevel_r;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			holdSync_r <= 3'h0;
			slowSync_r <= 3'h0;
			oscSync_r <= 3'h0;
		end else begin
			holdSync_r <= {holdSync_r[1:0], external_hold_input};
			slowSync_r <= {slowSync_r[1:0], slowClockIn};
			oscSync_r <= {oscSync_r[1:0], oscillatorOn};
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			holdLevel_r <= 1'b0;
			slowLevel_r <= 1'b0;
			oscLevel_r <= 1'b0;
		end else begin
			if (holdSync_r[1] == holdSync_r[2]) begin
				holdLevel_r <= holdSync_r[2];
			end
			if (slowSync_r[1] == slowSync_r[2]) begin
				slowLevel_r <= slowSync_r[2];
			end
			if (oscSync_r[1] == oscSync_r[2]) begin
				oscLevel_r <= oscSync_r[2];
			end
		end
	end

	// Timers
	swcrt_timer_if waitTif ();
	swcrt_timer_if settleTif ();
	swcrt_timer_if releaseTif ();

	swcrt_tick_timer #(.TICK_CYCLES(TICK_CYCLES)) waitTimer (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.tif(waitTif)
	);

	swcrt_tick_timer #(.TICK_CYCLES(TICK_CYCLES)) settleTimer (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.tif(settleTif)
	);

	swcrt_tick_timer #(.TICK_CYCLES(TICK_CYCLES)) releaseTimer (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.tif(releaseTif)
	);

	// Wait slot
	swcrt_wait_state_type waitState_r;
	logic seqHold_r;
	logic waitTimedOut_r;
	logic waitApplies;
	logic waitEnter;
	logic waitStartTimer;

	always_comb begin
		unique case (waitDir)
			2'b00: waitApplies = 1'b0;
			2'b01: waitApplies = seqDirUp;
			2'b10: waitApplies = !seqDirUp;
			2'b11: waitApplies = 1'b1;
		endcase
	end

	// A timed wait with code 0 adds nothing, so it never enters the hold
	assign waitEnter = seqSlotStart && waitApplies
		&& seqSlotIndex == stepIndex_r[3:0]
		&& (!waitSrcTimer || waitTime != 4'h0);
	assign waitStartTimer = waitEnter && (waitSrcTimer || waitTimeoutEn);
	assign waitTif.start = waitStartTimer;
	assign waitTif.ticks = waitSrcTimer ? waitTicks(waitTime)
		: swcrt_ticks_type'(TIMEOUT_TICKS);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			waitState_r <= WAIT_IDLE;
			waitTimedOut_r <= 1'b0;
		end else begin
			unique case (waitState_r)
				WAIT_IDLE: begin
					if (waitEnter) begin
						waitTimedOut_r <= 1'b0;
						waitState_r <= waitSrcTimer ? WAIT_TIMER : WAIT_EXT;
					end
				end
				WAIT_EXT: begin
					if (holdLevel_r) begin
						waitState_r <= WAIT_DONE;
					end else if (waitTimeoutEn && waitTif.done) begin
						waitTimedOut_r <= 1'b1;
						waitState_r <= WAIT_DONE;
					end
				end
				WAIT_TIMER: begin
					if (waitTif.done) begin
						waitState_r <= WAIT_DONE;
					end
				end
				WAIT_DONE: begin
					// Fresh entry into the wait step waits again; any other slot frees it
					if (waitEnter) begin
						waitTimedOut_r <= 1'b0;
						waitState_r <= waitSrcTimer ? WAIT_TIMER : WAIT_EXT;
					end else if (seqSlotStart) begin
						waitState_r <= WAIT_IDLE;
					end
				end
			endcase
		end
	end

	// Hold stays high until the condition is met; the engine advances at its boundary
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			seqHold_r <= 1'b0;
		end else if (waitEnter && (waitState_r == WAIT_IDLE || waitState_r == WAIT_DONE)) begin
			seqHold_r <= 1'b1;
		end else if (waitState_r == WAIT_EXT || waitState_r == WAIT_TIMER) begin
			seqHold_r <= !(waitState_r == WAIT_EXT ? (holdLevel_r
				|| (waitTimeoutEn && waitTif.done)) : waitTif.done);
		end else begin
			seqHold_r <= 1'b0;
		end
	end

	// Stabilization start
	logic [1:0] fallCount_r;
	logic slowLevelDly_r;
	logic oscLevelDly_r;
	logic settleStarted_r;
	logic settleDone_r;
	logic settleGo;
	logic fallEdge;

	assign fallEdge = slowLevelDly_r && !slowLevel_r;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			slowLevelDly_r <= 1'b0;
			oscLevelDly_r <= 1'b0;
			fallCount_r <= 2'h0;
		end else begin
			slowLevelDly_r <= slowLevel_r;
			oscLevelDly_r <= oscLevel_r;
			if (!oscLevel_r) begin
				fallCount_r <= 2'h0;
			end else if (fallEdge && fallCount_r != 2'(`SWCRT_OSC_FALL_EDGES)) begin
				fallCount_r <= fallCount_r + 2'h1;
			end
		end
	end

	assign settleGo = !settleStarted_r && (gateCtrl_r[`SWCRT_GATE_START_BIT]
		? (oscLevel_r && !oscLevelDly_r)
		: (fallEdge && fallCount_r == 2'(`SWCRT_OSC_FALL_EDGES - 1)));
	assign settleTif.start = settleGo;
	assign settleTif.ticks = settleTicks(settleCode);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			settleStarted_r <= 1'b0;
			settleDone_r <= 1'b0;
		end else if (!oscLevel_r) begin
			settleStarted_r <= 1'b0;
			settleDone_r <= 1'b0;
		end else begin
			if (settleGo) begin
				settleStarted_r <= 1'b1;
			end
			if (settleTif.done) begin
				settleDone_r <= 1'b1;
			end
		end
	end

	// Gated slow clock outputs
	logic counterClock_r;
	logic slowClockOut_r;
	logic counterAllow;
	logic outAllow;

	assign counterAllow = !gateCtrl_r[`SWCRT_GATE_RTC_BIT] || settleDone_r;
	assign outAllow = gateCtrl_r[`SWCRT_GATE_OUT_EN_BIT] && !slow_clock_output_pause
		&& (!gateCtrl_r[`SWCRT_GATE_OUT_BIT] || settleDone_r);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			counterClock_r <= 1'b0;
			slowClockOut_r <= 1'b0;
		end else begin
			counterClock_r <= counterAllow && slowLevel_r;
			slowClockOut_r <= outAllow && slowLevel_r;
		end
	end

	// Reset release
	logic trigHit;
	logic releaseArmed_r;
	logic sysReset_n_r;

	always_comb begin
		unique case (trigSel)
			TRIG_EXT_WAKE: trigHit = external_wake;
			TRIG_SYSTEM_UP: trigHit = system_domain_up;
			TRIG_POWER_UP: trigHit = power_domain_up;
			TRIG_LEAVE_RESET: trigHit = leaveResetMode;
		endcase
	end

	// Only the first trigger counts; later ones cannot restart a release
	assign releaseTif.start = trigHit && !releaseArmed_r && !sysReset_n_r;
	assign releaseTif.ticks = releaseTicks(releaseCode);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			releaseArmed_r <= 1'b0;
			sysReset_n_r <= 1'b0;
		end else begin
			if (releaseTif.start) begin
				releaseArmed_r <= 1'b1;
			end
			if (releaseTif.done) begin
				sysReset_n_r <= 1'b1;
			end
		end
	end

	assign regRdData = regRdData_r;
	assign seqHold = seqHold_r;
	assign waitTimedOut = waitTimedOut_r;
	assign counterClock = counterClock_r;
	assign slow_clock_output = slowClockOut_r;
	assign settleDone = settleDone_r;
	assign system_reset_out_n = sysReset_n_r;
endmodule : swcrt_top

// *** inc/swcrt_defines.svh ***
// Offsets, field positions, reset values and timing counts of the sequencer timing helpers
`ifndef SWCRT_DEFINES_SVH
`define SWCRT_DEFINES_SVH

`define SWCRT_ADDR_STEP_INDEX 8'h92
`define SWCRT_ADDR_WAIT_CTRL 8'h97
`define SWCRT_ADDR_GATE_CTRL 8'h98
`define SWCRT_ADDR_RELEASE_CTRL 8'h99

`define SWCRT_RST_STEP_INDEX 8'h00
`define SWCRT_RST_WAIT_CTRL 8'h00
`define SWCRT_RST_GATE_CTRL 8'h00
`define SWCRT_RST_RELEASE_CTRL 8'h00

`define SWCRT_WAIT_STEP_LSB 0
`define SWCRT_WAIT_DIR_MSB 7
`define SWCRT_WAIT_DIR_LSB 6
`define SWCRT_WAIT_TIMEOUT_BIT 5
`define SWCRT_WAIT_SRC_BIT 4
`define SWCRT_WAIT_TIME_MSB 3
`define SWCRT_WAIT_TIME_LSB 0

`define SWCRT_GATE_OUT_EN_BIT 7
`define SWCRT_GATE_RTC_BIT 6
`define SWCRT_GATE_OUT_BIT 5
`define SWCRT_GATE_START_BIT 4
`define SWCRT_GATE_CRYSTAL_BIT 3
`define SWCRT_GATE_SETTLE_MSB 2
`define SWCRT_GATE_SETTLE_LSB 0

`define SWCRT_REL_EVENT_MSB 7
`define SWCRT_REL_EVENT_LSB 6
`define SWCRT_REL_TIMER_MSB 5
`define SWCRT_REL_TIMER_LSB 0

`define SWCRT_CLK_PERIOD_PS 5000
`define SWCRT_TICK_US 512
`define SWCRT_TICK_CYCLES ((`SWCRT_TICK_US * 1000000) / `SWCRT_CLK_PERIOD_PS)
`define SWCRT_TIMEOUT_MS 500
`define SWCRT_TIMEOUT_TICKS ((`SWCRT_TIMEOUT_MS * 1000) / `SWCRT_TICK_US)
`define SWCRT_SETTLE_STEP_TICKS 1024
`define SWCRT_RELEASE_UNIT_US 1024
`define SWCRT_RELEASE_UNIT_TICKS (`SWCRT_RELEASE_UNIT_US / `SWCRT_TICK_US)
`define SWCRT_RELEASE_LONG_MULT 32
`define SWCRT_RELEASE_LONG_BASE 31
`define SWCRT_OSC_FALL_EDGES 3

`endif

// *** inc/swcrt_pkg.sv ***
// Types shared by the sequencer timing helpers
package swcrt_pkg;
	typedef enum logic [1:0] {
		WAIT_IDLE,
		WAIT_EXT,
		WAIT_TIMER,
		WAIT_DONE
	} swcrt_wait_state_type;

	typedef enum logic [1:0] {
		TRIG_EXT_WAKE,
		TRIG_SYSTEM_UP,
		TRIG_POWER_UP,
		TRIG_LEAVE_RESET
	} swcrt_trigger_type;

	typedef logic [15:0] swcrt_ticks_type;
endpackage : swcrt_pkg

// *** inc/swcrt_timer_if.sv ***
// Start and expiry handshake between the top block and one tick timer
`timescale 1ns/1ps
interface swcrt_timer_if;
	import swcrt_pkg::*;
	logic start;
	swcrt_ticks_type ticks;
	logic busy;
	logic done;
	modport ctrl (output start, output ticks, input busy, input done);
	modport timer (input start, input ticks, output busy, output done);
endinterface : swcrt_timer_if

// *** design/swcrt_tick_timer.sv ***
// Countdown of whole ticks with its own prescaler, restarted by start
`timescale 1ns/1ps
`include "swcrt_defines.svh"
module swcrt_tick_timer #(
	parameter int TICK_CYCLES = `SWCRT_TICK_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Control
	swcrt_timer_if.timer tif
);
	import swcrt_pkg::*;

	// Own prescaler so a start never lands mid-tick and shortens the delay
	logic [31:0] preCount_r;
	swcrt_ticks_type tickCount_r;
	logic busy_r;
	logic done_r;
	logic tickHit;

	assign tickHit = (preCount_r == 32'(TICK_CYCLES - 1));

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			preCount_r <= 32'h0000_0000;
		end else if (tif.start || !busy_r || tickHit) begin
			preCount_r <= 32'h0000_0000;
		end else begin
			preCount_r <= preCount_r + 32'h0000_0001;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tickCount_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else if (tif.start) begin
			tickCount_r <= tif.ticks;
			busy_r <= (tif.ticks != '0);
			done_r <= (tif.ticks == '0);
		end else if (busy_r && tickHit) begin
			tickCount_r <= tickCount_r - 16'h0001;
			busy_r <= (tickCount_r != 16'h0001);
			done_r <= (tickCount_r == 16'h0001);
		end else begin
			done_r <= 1'b0;
		end
	end

	assign tif.busy = busy_r;
	assign tif.done = done_r;
endmodule : swcrt_tick_timer

// *** verif/swcrt_top_asserts.sv ***
// Port checks of the sequencer timing block
`timescale 1ns/1ps
`include "swcrt_defines.svh"
module swcrt_top_asserts #(
	parameter int TICK_CYCLES = 4,
	parameter int TIMEOUT_TICKS = 5
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Register writes
	input wire logic regWrEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	// Sequencer
	input wire logic [3:0] seqSlotIndex,
	input wire logic seqSlotStart,
	input wire logic seqDirUp,
	input wire logic seqHold,
	// Slow clock
	input wire logic counterClock,
	input wire logic settleDone,
	// Reset release
	input wire logic external_wake,
	input wire logic system_domain_up,
	input wire logic power_domain_up,
	input wire logic leaveResetMode,
	input wire logic system_reset_out_n
);
	logic [7:0] stepR, waitR, gateR, relR;
	logic [3:0] trigs;
	logic trig, take, armed;
	int holdCnt, age, relWait;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	assign trigs = {leaveResetMode, power_domain_up, system_domain_up, external_wake};
	assign trig = trigs[relR[7:6]];
	assign take = seqSlotStart && !seqHold && seqSlotIndex == stepR[3:0]
		&& (seqDirUp ? waitR[6] : waitR[7]) && (!waitR[4] || waitR[3:0] != 4'h0);
	assign relWait = (relR[5:0] < 6'h20 ? relR[5:0] * 2 : (relR[5:0] - 31) * 64) * TICK_CYCLES;
	// Shadow copies; early lost writes to 0x98 are never made by the bench
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			stepR <= `SWCRT_RST_STEP_INDEX;
			waitR <= `SWCRT_RST_WAIT_CTRL;
			gateR <= `SWCRT_RST_GATE_CTRL;
			relR <= `SWCRT_RST_RELEASE_CTRL;
		end else if (regWrEn) begin
			case (regAddr)
				`SWCRT_ADDR_STEP_INDEX: stepR <= regWrData;
				`SWCRT_ADDR_WAIT_CTRL: waitR <= regWrData;
				`SWCRT_ADDR_GATE_CTRL: gateR <= regWrData;
				`SWCRT_ADDR_RELEASE_CTRL: relR <= regWrData;
				default: ;
			endcase
		end
	end
	// Counters replace long repetitions
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			holdCnt <= 0;
		end else begin
			holdCnt <= seqHold ? holdCnt + 1 : 0;
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			armed <= 1'b0;
			age <= 0;
		end else begin
			if (!system_reset_out_n && trig) armed <= 1'b1;
			if (armed) age <= age + 1;
		end
	end
	property p_dir_off;
		seqSlotStart && !seqHold && waitR[7:6] == 2'b00 |=> !seqHold;
	endproperty
	a_dir_off: assert property (p_dir_off) else $error("hold with direction off");
	property p_take;
		take |=> seqHold;
	endproperty
	a_take: assert property (p_take) else $error("wait slot not held");
	property p_other_step;
		seqSlotStart && !seqHold && seqSlotIndex != stepR[3:0] |=> !seqHold;
	endproperty
	a_other_step: assert property (p_other_step) else $error("hold in wrong step");
	property p_timed;
		$fell(seqHold) && waitR[4] && waitR[3:0] == 4'h1
			|-> holdCnt >= TICK_CYCLES - 1 && holdCnt <= TICK_CYCLES + 4;
	endproperty
	a_timed: assert property (p_timed) else $error("timed wait length wrong");
	property p_timeout;
		seqHold && !waitR[4] && waitR[5] |-> holdCnt <= TIMEOUT_TICKS * TICK_CYCLES + 6;
	endproperty
	a_timeout: assert property (p_timeout) else $error("external wait overran");
	property p_rel_time;
		$rose(system_reset_out_n) |-> age >= relWait - 1 && age <= relWait + 4;
	endproperty
	a_rel_time: assert property (p_rel_time) else $error("reset release time wrong");
	property p_rst_low;
		!armed |-> !system_reset_out_n;
	endproperty
	a_rst_low: assert property (p_rst_low) else $error("reset released early");
	property p_rst_held;
		system_reset_out_n |=> system_reset_out_n;
	endproperty
	a_rst_held: assert property (p_rst_held) else $error("reset fell again");
	property p_cnt_gate;
		gateR[6] && $past(gateR[6], 2) && !settleDone && !$past(settleDone)
			&& !$past(settleDone, 2) |-> !counterClock;
	endproperty
	a_cnt_gate: assert property (p_cnt_gate) else $error("counter clock not gated");
endmodule : swcrt_top_asserts
bind swcrt_top swcrt_top_asserts #(.TICK_CYCLES(TICK_CYCLES), .TIMEOUT_TICKS(TIMEOUT_TICKS)) u_chk (
	.ref_clk, .arst_n, .regWrEn, .regAddr, .regWrData, .seqSlotIndex, .seqSlotStart,
	.seqDirUp, .seqHold, .counterClock, .settleDone, .external_wake, .system_domain_up,
	.power_domain_up, .leaveResetMode, .system_reset_out_n
);

// *** verif/swcrt_partner_model.sv ***
// Far side model: slow oscillator and external hold source
`timescale 1ns/1ps
module swcrt_partner_model (
	// Clock
	input wire logic ref_clk,
	// Commands
	input wire logic oscillatorOn,
	input wire logic holdArm,
	input wire logic [7:0] holdDelay,
	// Pins toward the block
	output logic slowClockIn = 1'b0,
	output logic external_hold_input = 1'b0
);
	int oscCnt = 0;
	int armCnt = 0;
	// Oscillator stands still while off, so no stray falling edges
	always @(posedge ref_clk) begin
		oscCnt <= oscillatorOn ? oscCnt + 1 : 0;
		if (!oscillatorOn) slowClockIn <= 1'b0;
		else if (oscCnt % 8 == 7) slowClockIn <= !slowClockIn;
	end
	// Delay FF means the source never answers
	always @(posedge ref_clk) begin
		armCnt <= holdArm ? armCnt + 1 : 0;
		external_hold_input <= holdArm && holdDelay != 8'hFF && armCnt >= holdDelay;
	end
endmodule : swcrt_partner_model

// *** verif/swcrt_top_test.sv ***
// Self-checking bench of the sequencer timing block
`timescale 1ns/1ps
`include "swcrt_defines.svh"
module swcrt_top_test;
	localparam int TICKS = 4;
	localparam int TOUT = 5;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic [7:0] regRdData;
	logic [3:0] seqSlotIndex = 4'h0;
	logic seqSlotStart = 1'b0;
	logic seqDirUp = 1'b1;
	logic oscillatorOn = 1'b0;
	logic slow_clock_output_pause = 1'b0;
	logic [3:0] trigs = 4'h0;
	logic holdArm = 1'b0;
	logic [7:0] holdDelay = 8'h00;
	logic seqHold, waitTimedOut, external_hold_input, slowClockIn;
	logic counterClock, slow_clock_output, settleDone, system_reset_out_n;
	logic rdLate = 1'b0;
	logic crystalIn = 1'b1;
	logic [1:0] seen;
	logic [7:0] expQ[$];
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int n, c, w;
	int codes[4] = '{0, 2, 33, 1};
	always #2.5 ref_clk = !ref_clk;
	swcrt_top #(.TICK_CYCLES(TICKS), .TIMEOUT_TICKS(TOUT)) dut_u (
		.ref_clk, .arst_n, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
		.seqSlotIndex, .seqSlotStart, .seqDirUp, .seqHold, .waitTimedOut,
		.external_hold_input, .slowClockIn, .oscillatorOn, .slow_clock_output_pause,
		.backupCrystalPresent(crystalIn), .counterClock, .slow_clock_output, .settleDone,
		.external_wake(trigs[0]), .system_domain_up(trigs[1]), .power_domain_up(trigs[2]),
		.leaveResetMode(trigs[3]), .system_reset_out_n
	);
	swcrt_partner_model partner_u (
		.ref_clk, .oscillatorOn, .holdArm, .holdDelay, .slowClockIn, .external_hold_input
	);
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check
	task automatic conclude();
		$display("Checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	task automatic doReset();
		@(negedge ref_clk);
		arst_n = 1'b0;
		repeat (16) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (2) @(negedge ref_clk);
	endtask : doReset
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge ref_clk);
		regWrEn = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge ref_clk);
		regAddr = a;
		regRdEn = 1'b1;
		expQ.push_back(e);
		@(negedge ref_clk);
		regRdEn = 1'b0;
	endtask : rd
	task automatic slot(input logic [3:0] idx, input logic up);
		@(negedge ref_clk);
		seqSlotIndex = idx;
		seqDirUp = up;
		seqSlotStart = 1'b1;
		@(negedge ref_clk);
		seqSlotStart = 1'b0;
		@(negedge ref_clk);
	endtask : slot
	task automatic waitFor(ref logic sig, input logic lvl, output int len);
		len = 0;
		while (sig !== lvl && len < 6000) begin
			@(negedge ref_clk);
			len++;
			if (!settleDone && oscillatorOn) check("gated", {counterClock, slow_clock_output}, 0);
		end
	endtask : waitFor
	// Read data is compared one cycle after the strobe
	always @(posedge ref_clk) rdLate <= regRdEn;
	always @(negedge ref_clk) begin
		if (rdLate) check("regRdData", regRdData, expQ.pop_front());
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			conclude();
		end
	end
	initial begin
		void'($urandom(32'h735151db));
		n = $urandom;
		crystalIn = n[0];
		doReset();
		check("system_reset_out_n", system_reset_out_n, 1'b0);
		rd(`SWCRT_ADDR_WAIT_CTRL, `SWCRT_RST_WAIT_CTRL);
		rd(`SWCRT_ADDR_GATE_CTRL, {4'h0, crystalIn, 3'h0});
		for (int i = 0; i < 4; i++) begin
			n = $urandom;
			wr(`SWCRT_ADDR_RELEASE_CTRL, n[7:0]);
			rd(`SWCRT_ADDR_RELEASE_CTRL, n[7:0]);
			wr(8'h9A, n[7:0]);
			rd(8'h9A, 8'h00);
		end
		wr(`SWCRT_ADDR_STEP_INDEX, 8'h05);
		for (int d = 0; d < 8; d++) begin
			wr(`SWCRT_ADDR_WAIT_CTRL, {d[2:1], 6'h11});
			slot(4'h5, d[0]);
			check("seqHold", seqHold, d[0] ? d[1] : d[2]);
			waitFor(seqHold, 1'b0, n);
		end
		n = 6 + $urandom % 10;
		slot(n[3:0], 1'b1);
		check("seqHold", seqHold, 1'b0);
		for (c = 0; c < 5; c++) begin
			wr(`SWCRT_ADDR_WAIT_CTRL, 8'hD0 | c[7:0]);
			slot(4'h5, 1'b1);
			waitFor(seqHold, 1'b0, n);
			w = c == 0 ? 0 : (1 << (c - 1)) * TICKS;
			check("timedWait", n + 2 >= w && n <= w + 3, 1'b1);
		end
		wr(`SWCRT_ADDR_WAIT_CTRL, 8'hC0);
		holdDelay = 8'd40;
		holdArm = 1'b1;
		slot(4'h5, 1'b0);
		waitFor(seqHold, 1'b0, n);
		check("extWait", n >= 35 && n <= 50, 1'b1);
		check("waitTimedOut", waitTimedOut, 1'b0);
		holdArm = 1'b0;
		// Let the synchronised pin fall before the next wait is entered
		repeat (8) @(negedge ref_clk);
		wr(`SWCRT_ADDR_WAIT_CTRL, 8'hE0);
		holdDelay = 8'hFF;
		holdArm = 1'b1;
		slot(4'h5, 1'b1);
		waitFor(seqHold, 1'b0, n);
		check("timeoutLen", n >= 16 && n <= 26, 1'b1);
		check("waitTimedOut", waitTimedOut, 1'b1);
		holdArm = 1'b0;
		for (int m = 1; m >= 0; m--) begin
			oscillatorOn = 1'b0;
			// Off long enough to clear the settle state and still the clock
			repeat (8) @(negedge ref_clk);
			wr(`SWCRT_ADDR_GATE_CTRL, {3'b111, m[0], 4'h1});
			oscillatorOn = 1'b1;
			waitFor(settleDone, 1'b1, n);
			w = 4096 + (m == 0 ? 40 : 0);
			check("settleTime", n >= w && n <= w + 24, 1'b1);
		end
		seen = 2'b00;
		repeat (64) begin
			@(negedge ref_clk);
			seen = seen | {counterClock, slow_clock_output};
		end
		check("clocksRun", seen, 2'b11);
		slow_clock_output_pause = 1'b1;
		repeat (8) @(negedge ref_clk);
		seen = 2'b00;
		repeat (64) begin
			@(negedge ref_clk);
			seen = seen | {counterClock, slow_clock_output};
		end
		check("pausedOut", seen, 2'b10);
		// Oscillator off, so reset leaves no ungated clock for the gating check
		oscillatorOn = 1'b0;
		for (int e = 0; e < 4; e++) begin
			doReset();
			c = codes[e];
			wr(`SWCRT_ADDR_RELEASE_CTRL, {e[1:0], c[5:0]});
			trigs = 4'hF ^ (4'h1 << e);
			@(negedge ref_clk);
			trigs = 4'h0;
			repeat (4) @(negedge ref_clk);
			check("system_reset_out_n", system_reset_out_n, 1'b0);
			trigs[e] = 1'b1;
			@(negedge ref_clk);
			trigs = 4'h0;
			waitFor(system_reset_out_n, 1'b1, n);
			w = c < 32 ? c * 2 * TICKS : (c - 31) * 64 * TICKS;
			check("releaseDelay", n + 1 >= w && n <= w + 3, 1'b1);
			repeat (8) @(negedge ref_clk);
			check("system_reset_out_n", system_reset_out_n, 1'b1);
		end
		conclude();
	end
endmodule : swcrt_top_test
